/* hw/hfp_regs.svh */
`ifndef HFP_REGS_SVH
`define HFP_REGS_SVH
// Host port word addresses
`define HFP_ADDR_W 6
`define HFP_RXD_WIN 2'b00
`define HFP_TXD_WIN 2'b01
`define HFP_RXS_POP 6'h20
`define HFP_RXS_NONPOP_STATUS_PORT 6'h21
`define HFP_TXS_POP 6'h22
`define HFP_TXS_NONPOP_STATUS_PORT 6'h23
`define HFP_CTRL 6'h24
`define HFP_STAT 6'h25
`define HFP_CFG 6'h26
// Control and status bit positions
`define HFP_CTRL_SRST 0
`define HFP_ST_RXOVF 0
`define HFP_ST_TXSOVF 1
`define HFP_ST_LINK 2
`define HFP_ST_ERR 3
`define HFP_ST_TXEMPTY 4
// Size limit fields in the configuration word
`define HFP_CFG_RXD_LSB 0
`define HFP_CFG_RXS_LSB 8
`define HFP_CFG_TXD_LSB 16
`define HFP_LIM_W 8
// Reset values
`define HFP_CFG_RST 32'h00ffffff
`define HFP_FLAG_RST 1'b0
`endif

/* hw/hfp_pkg.sv */
package hfp_pkg;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [31:0] wdata;
  } hfp_req_s;
  typedef enum {HFP_RXS, HFP_RXD, HFP_TXS, HFP_TXD} hfp_queue_e;
endpackage

/* hw/hfp_core.sv */
// Function
// R1 - Writes to read-only locations change nothing stored.
// R2 - Reads of write-only locations return zero.
// R3 - Writing one clears a write_one_clear bit; zero leaves it.
// R4 - A read_clear bit clears when the host reads it.
// R5 - Latch_low_bit and latch_high_bit hold until the register is read.
// R6 - Soft_reset_immune fields survive software reset; system reset restores them.
// R7 - Host writes zeros to reserved bits and ignores their read value.
// R8 - Host never writes reserved registers; their reads are undefined.
// R9 - System or software reset loads every register with its default; the code keeps cfg_q through software reset.
// R10 - Software programs operating parameters after reset.
// R11 - Four queues; data and receive status sizes set by configuration.
// R12 - Host writes to receive queue ports have no effect.
// R13 - Reading receive status pop port returns and removes the head.
// R14 - Receive status nonpop_status_port port returns the head without removing it.
// R15 - Every receive data read pops; sixteen aliased word addresses.
// R16 - Reading transmit status pop port returns and removes the head.
// R17 - Transmit status nonpop_status_port port returns the head, queue unchanged.
// R18 - Transmit data queue is write only, sixteen aliased addresses.
`timescale 1ns/1ps
`include "hfp_regs.svh"
module hfp_core #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Host port
  input wire logic host_req_valid_in,
  input wire hfp_pkg::hfp_req_s host_req_in,
  output logic [31:0] host_rdata_out,
  output logic host_ack_out,
  // Receive status fill side
  input wire logic rx_sts_valid_in,
  input wire logic [31:0] rx_sts_data_in,
  output logic rx_sts_ready_out,
  // Receive data fill side
  input wire logic rx_data_valid_in,
  input wire logic [31:0] rx_data_in,
  output logic rx_data_ready_out,
  // Transmit status fill side
  input wire logic tx_sts_valid_in,
  input wire logic [31:0] tx_sts_data_in,
  output logic tx_sts_ready_out,
  // Transmit data drain side
  output logic tx_data_valid_out,
  output logic [31:0] tx_data_out,
  input wire logic tx_data_ready_in,
  // Datapath events and reset out
  input wire logic mac_link_in,
  input wire logic mac_err_in,
  output logic soft_rst_out
);
  localparam int NQ = 4;
  localparam int I_RXS = int'(hfp_pkg::HFP_RXS);
  localparam int I_RXD = int'(hfp_pkg::HFP_RXD);
  localparam int I_TXS = int'(hfp_pkg::HFP_TXS);
  localparam int I_TXD = int'(hfp_pkg::HFP_TXD);

  logic [31:0] mem_q [NQ][DEPTH];
  logic [AW-1:0] wp_q [NQ];
  logic [AW-1:0] rp_q [NQ];
  logic [AW:0] cnt_q [NQ];
  logic [AW:0] cnt_d [NQ];
  logic rdy_q [NQ];
  logic push [NQ];
  logic pop [NQ];
  logic [31:0] din [NQ];
  logic [31:0] head [NQ];
  logic [`HFP_LIM_W-1:0] lim [NQ];
  logic [31:0] cfg_q;
  logic srst_q;
  logic rst_any;
  logic rx_ovf_q, txs_ovf_q, link_ll_q, err_lh_q;
  logic [31:0] b0_q, b1_q;
  logic [1:0] bcnt_q;
  logic tx_valid_q;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q;
  logic rd, wr, hit_rxd, hit_txd, rd_stat, wr_stat, deq;
  logic [31:0] stat;
  logic [5:0] addr;
  assign rst_any = sys_rst_in | srst_q;
  assign addr = host_req_in.addr;
  assign rd = host_req_valid_in & ~host_req_in.wr;
  assign wr = host_req_valid_in & host_req_in.wr;
  assign hit_rxd = addr[5:4] == `HFP_RXD_WIN;
  assign hit_txd = addr[5:4] == `HFP_TXD_WIN;
  assign rd_stat = rd & (addr == `HFP_STAT);
  assign wr_stat = wr & (addr == `HFP_STAT);
  assign deq = tx_valid_q & tx_data_ready_in;
  // R11 size limits
  assign lim[I_RXS] = cfg_q[`HFP_CFG_RXS_LSB +: `HFP_LIM_W];
  assign lim[I_RXD] = cfg_q[`HFP_CFG_RXD_LSB +: `HFP_LIM_W];
  assign lim[I_TXS] = {`HFP_LIM_W{1'b1}};
  assign lim[I_TXD] = cfg_q[`HFP_CFG_TXD_LSB +: `HFP_LIM_W];
  assign din[I_RXS] = rx_sts_data_in;
  assign din[I_RXD] = rx_data_in;
  assign din[I_TXS] = tx_sts_data_in;
  assign din[I_TXD] = host_req_in.wdata;
  // R1 R12 host writes never fill
  assign push[I_RXS] = rx_sts_valid_in & rdy_q[I_RXS];
  assign push[I_RXD] = rx_data_valid_in & rdy_q[I_RXD];
  assign push[I_TXS] = tx_sts_valid_in & rdy_q[I_TXS];
  // R18 aliased write window
  assign push[I_TXD] = wr & hit_txd & rdy_q[I_TXD];
  // R13 destructive read
  assign pop[I_RXS] = rd & (addr == `HFP_RXS_POP) & (cnt_q[I_RXS] != '0);
  // R15 aliased popping read
  assign pop[I_RXD] = rd & hit_rxd & (cnt_q[I_RXD] != '0);
  // R16 destructive read
  assign pop[I_TXS] = rd & (addr == `HFP_TXS_POP) & (cnt_q[I_TXS] != '0);
  // Drain only into free buffer slots so a stalled receiver loses nothing
  assign pop[I_TXD] = (cnt_q[I_TXD] != '0) & (bcnt_q != 2'd2);
  // One queue per entry; reads never touch the storage
  for (genvar g = 0; g < NQ; g++) begin : g_q
    assign head[g] = mem_q[g][rp_q[g]];
    always_comb begin
      cnt_d[g] = cnt_q[g] + (AW+1)'(push[g]) - (AW+1)'(pop[g]);
    end
    always_ff @(posedge clock_in) begin
      if (push[g]) begin
        mem_q[g][wp_q[g]] <= din[g];
      end
    end
    // R9 queues empty on either reset
    always_ff @(posedge clock_in) begin
      if (rst_any) begin
        wp_q[g] <= '0;
        rp_q[g] <= '0;
        cnt_q[g] <= '0;
        rdy_q[g] <= 1'b0;
      end else begin
        wp_q[g] <= wp_q[g] + AW'(push[g]);
        rp_q[g] <= rp_q[g] + AW'(pop[g]);
        cnt_q[g] <= cnt_d[g];
        rdy_q[g] <= (32'(cnt_d[g]) < 32'(lim[g])) && (32'(cnt_d[g]) < DEPTH);
      end
    end
  end
  // Two-entry transmit buffer
  always_ff @(posedge clock_in) begin
    if (rst_any) begin
      bcnt_q <= 2'h0;
      tx_valid_q <= 1'b0;
      b0_q <= 32'h0;
      b1_q <= 32'h0;
    end else begin
      case ({pop[I_TXD], deq})
        2'b10: begin
          if (bcnt_q == 2'h0) begin
            b0_q <= head[I_TXD];
          end else begin
            b1_q <= head[I_TXD];
          end
          bcnt_q <= bcnt_q + 2'h1;
          tx_valid_q <= 1'b1;
        end
        2'b01: begin
          b0_q <= b1_q;
          bcnt_q <= bcnt_q - 2'h1;
          tx_valid_q <= bcnt_q == 2'h2;
        end
        2'b11: begin
          if (bcnt_q == 2'h1) begin
            b0_q <= head[I_TXD];
          end else begin
            b0_q <= b1_q;
            b1_q <= head[I_TXD];
          end
        end
        default: begin
        end
      endcase
    end
  end
  // R3 write_one_clear, set wins
  always_ff @(posedge clock_in) begin
    if (rst_any) begin
      rx_ovf_q <= `HFP_FLAG_RST;
    end else if (rx_data_valid_in & ~rdy_q[I_RXD]) begin
      rx_ovf_q <= 1'b1;
    end else if (wr_stat & host_req_in.wdata[`HFP_ST_RXOVF]) begin
      rx_ovf_q <= 1'b0;
    end
  end
  // R4 read_clear, set wins
  always_ff @(posedge clock_in) begin
    if (rst_any) begin
      txs_ovf_q <= `HFP_FLAG_RST;
    end else if (tx_sts_valid_in & ~rdy_q[I_TXS]) begin
      txs_ovf_q <= 1'b1;
    end else if (rd_stat) begin
      txs_ovf_q <= 1'b0;
    end
  end
  // R5 latch_low_bit and latch_high_bit
  always_ff @(posedge clock_in) begin
    if (rst_any) begin
      link_ll_q <= `HFP_FLAG_RST;
      err_lh_q <= `HFP_FLAG_RST;
    end else begin
      if (rd_stat) begin
        link_ll_q <= mac_link_in;
      end else if (~mac_link_in) begin
        link_ll_q <= 1'b0;
      end
      if (mac_err_in) begin
        err_lh_q <= 1'b1;
      end else if (rd_stat) begin
        err_lh_q <= 1'b0;
      end
    end
  end
  // R6 soft_reset_immune limits, only system reset restores
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg_q <= `HFP_CFG_RST;
    end else if (wr & (addr == `HFP_CFG)) begin
      cfg_q <= host_req_in.wdata;
    end
  end
  // Self_clearing software reset, one cycle wide
  always_ff @(posedge clock_in) begin
    if (rst_any) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr & (addr == `HFP_CTRL) & host_req_in.wdata[`HFP_CTRL_SRST];
    end
  end

  always_comb begin
    stat = 32'h0;
    stat[`HFP_ST_RXOVF] = rx_ovf_q;
    stat[`HFP_ST_TXSOVF] = txs_ovf_q;
    stat[`HFP_ST_LINK] = link_ll_q;
    stat[`HFP_ST_ERR] = err_lh_q;
    stat[`HFP_ST_TXEMPTY] = (cnt_q[I_TXD] == '0) & ~tx_valid_q;
  end
  // R2 write-only ports read zero; R14 R17 nonpop_status_port returns head
  always_comb begin
    rdata_d = 32'h0;
    if (hit_rxd) begin
      rdata_d = (cnt_q[I_RXD] != '0) ? head[I_RXD] : 32'h0;
    end else if ((addr == `HFP_RXS_POP) | (addr == `HFP_RXS_NONPOP_STATUS_PORT)) begin
      rdata_d = (cnt_q[I_RXS] != '0) ? head[I_RXS] : 32'h0;
    end else if ((addr == `HFP_TXS_POP) | (addr == `HFP_TXS_NONPOP_STATUS_PORT)) begin
      rdata_d = (cnt_q[I_TXS] != '0) ? head[I_TXS] : 32'h0;
    end else if (addr == `HFP_STAT) begin
      rdata_d = stat;
    end else if (addr == `HFP_CFG) begin
      rdata_d = cfg_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= host_req_valid_in;
      rdata_q <= rd ? rdata_d : 32'h0;
    end
  end
  assign host_rdata_out = rdata_q;
  assign host_ack_out = ack_q;
  assign rx_sts_ready_out = rdy_q[I_RXS];
  assign rx_data_ready_out = rdy_q[I_RXD];
  assign tx_sts_ready_out = rdy_q[I_TXS];
  assign tx_data_valid_out = tx_valid_q;
  assign tx_data_out = b0_q;
  assign soft_rst_out = srst_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_ro;
    wr & (addr == `HFP_RXS_NONPOP_STATUS_PORT) & ~push[I_RXS] & ~srst_q |=> cnt_q[I_RXS] == $past(cnt_q[I_RXS]);
  endproperty
  a_ro: assert property (p_ro) else $error("write to read-only port changed queue"); // R1 R12
  property p_wo;
    rd & hit_txd |=> host_ack_out && host_rdata_out == 32'h0;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only read not zero"); // R2
  property p_w1c;
    wr_stat & host_req_in.wdata[`HFP_ST_RXOVF] & rdy_q[I_RXD] & ~srst_q |=> ~rx_ovf_q;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // R3
  property p_rc;
    rd_stat & ~tx_sts_valid_in |=> ~txs_ovf_q;
  endproperty
  a_rc: assert property (p_rc) else $error("read did not clear"); // R4
  property p_lh;
    mac_err_in & ~srst_q |=> err_lh_q ##1 (err_lh_q || $past(rd_stat) || $past(srst_q));
  endproperty
  a_lh: assert property (p_lh) else $error("latched error lost"); // R5
  property p_imm;
    srst_q & ~(wr & (addr == `HFP_CFG)) |=> $stable(cfg_q);
  endproperty
  a_imm: assert property (p_imm) else $error("immune field changed by soft reset"); // R6
  property p_dflt;
    srst_q |=> cnt_q[I_RXD] == '0 && cnt_q[I_TXD] == '0 && bcnt_q == 2'h0 && !rx_ovf_q && !err_lh_q;
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults not loaded"); // R9
  property p_lim;
    32'(cnt_q[I_RXD]) <= DEPTH && 32'(cnt_q[I_TXD]) <= DEPTH;
  endproperty
  a_lim: assert property (p_lim) else $error("queue count above depth"); // R11
  property p_pop;
    pop[I_RXS] & ~push[I_RXS] & ~srst_q
      |=> cnt_q[I_RXS] == $past(cnt_q[I_RXS]) - 1'b1 && host_rdata_out == $past(head[I_RXS]);
  endproperty
  a_pop: assert property (p_pop) else $error("status pop wrong"); // R13
  property p_nonpop_status_port;
    rd & (addr == `HFP_RXS_NONPOP_STATUS_PORT) & (cnt_q[I_RXS] != '0) & ~push[I_RXS] & ~srst_q
      |=> cnt_q[I_RXS] == $past(cnt_q[I_RXS]) && host_rdata_out == $past(head[I_RXS]);
  endproperty
  a_nonpop_status_port: assert property (p_nonpop_status_port) else $error("nonpop_status_port changed queue"); // R14
  property p_alias;
    rd & hit_rxd & (cnt_q[I_RXD] != '0) & ~push[I_RXD] & ~srst_q |=> cnt_q[I_RXD] == $past(cnt_q[I_RXD]) - 1'b1;
  endproperty
  a_alias: assert property (p_alias) else $error("aliased data read did not pop"); // R15
  property p_tpop;
    pop[I_TXS] & ~push[I_TXS] & ~srst_q |=> cnt_q[I_TXS] == $past(cnt_q[I_TXS]) - 1'b1;
  endproperty
  a_tpop: assert property (p_tpop) else $error("tx status pop wrong"); // R16
  property p_tpeek;
    rd & (addr == `HFP_TXS_NONPOP_STATUS_PORT) & ~push[I_TXS] & ~srst_q |=> $stable(cnt_q[I_TXS]);
  endproperty
  a_tpeek: assert property (p_tpeek) else $error("tx nonpop_status_port changed queue"); // R17
  property p_txw;
    push[I_TXD] & ~pop[I_TXD] & ~srst_q |=> cnt_q[I_TXD] == $past(cnt_q[I_TXD]) + 1'b1;
  endproperty
  a_txw: assert property (p_txw) else $error("tx data write lost"); // R18
  c_pop: cover property (pop[I_RXS] ##1 host_ack_out);
  c_stall: cover property (bcnt_q == 2'h2 && !tx_data_ready_in);
  c_srst: cover property (srst_q);
  c_lh: cover property (err_lh_q && rd_stat);
endmodule

/* tb/hfp_host_model.sv */
`timescale 1ns/1ps
module hfp_host_model (
  // Clock
  input wire logic clock_in,
  // Request side
  output logic host_req_valid_out,
  output hfp_pkg::hfp_req_s host_req_out,
  // Answer side
  input wire logic [31:0] host_rdata_in,
  input wire logic host_ack_in
);
  logic got_ack;
  logic [31:0] got_data;
  initial begin
    host_req_valid_out = 1'b0;
    host_req_out = '0;
  end
  // One access: launched at the falling edge, held over the taking edge
  task automatic access(input logic wr, input logic [5:0] addr, input logic [31:0] wdata);
    // callers pass zeroed spare bits and mapped places only
    @(negedge clock_in);
    host_req_valid_out = 1'b1;
    host_req_out = '{wr: wr, addr: addr, wdata: wdata};
    @(negedge clock_in);
    got_ack = host_ack_in;
    got_data = host_rdata_in;
    host_req_valid_out = 1'b0;
    // Released bus must not look like a repeat of the request
    host_req_out = ~host_req_out;
  endtask
endmodule

/* tb/hfp_core_tb_top.sv */
`timescale 1ns/1ps
`include "hfp_regs.svh"
module hfp_core_tb_top;
  logic clock_in, sys_rst_in, hv, ack, tx_v, tx_r, srst, link, err;
  hfp_pkg::hfp_req_s hreq;
  logic [31:0] rdat, tx_d, w;
  logic [2:0] fv, frdy;
  logic [31:0] fd [3];
  logic [31:0] exp_q [$];
  int fails, n_tests, k;

  hfp_core dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .host_req_valid_in(hv), .host_req_in(hreq),
    .host_rdata_out(rdat), .host_ack_out(ack), .rx_sts_valid_in(fv[0]), .rx_sts_data_in(fd[0]),
    .rx_sts_ready_out(frdy[0]), .rx_data_valid_in(fv[1]), .rx_data_in(fd[1]), .rx_data_ready_out(frdy[1]),
    .tx_sts_valid_in(fv[2]), .tx_sts_data_in(fd[2]), .tx_sts_ready_out(frdy[2]), .tx_data_valid_out(tx_v),
    .tx_data_out(tx_d), .tx_data_ready_in(tx_r), .mac_link_in(link), .mac_err_in(err), .soft_rst_out(srst));
  hfp_host_model host (.clock_in(clock_in), .host_req_valid_out(hv), .host_req_out(hreq),
    .host_rdata_in(rdat), .host_ack_in(ack));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    chk32({31'h0, got}, {31'h0, exp}, m);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    host.access(1'b0, a, 32'h0);
    chk1(host.got_ack, 1'b1, "ack");
    d = host.got_data;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host.access(1'b1, a, d);
    chk1(host.got_ack, 1'b1, "ack");
  endtask

  // Fill one word into a queue; released data shows the inverse
  task automatic push(input int s, input logic [31:0] d);
    @(negedge clock_in);
    fv[s] = 1'b1;
    fd[s] = d;
    @(negedge clock_in);
    fv[s] = 1'b0;
    fd[s] = ~d;
  endtask

  // Push until the queue refuses, then one more to overflow it
  task automatic flood(input int s);
    for (int i = 0; i < 40 && frdy[s] === 1'b1; i++) push(s, $urandom);
    chk1(frdy[s], 1'b0, "full");
    push(s, $urandom);
  endtask

  function automatic logic [5:0] alias_addr(input logic [1:0] win, input int i);
    return {win, (i == 0) ? 4'h0 : (i == 3) ? 4'hf : 4'($urandom)};
  endfunction

  initial begin
    fails = 0;
    n_tests = 0;
    sys_rst_in = 1'b1;
    fv = 3'b000;
    fd = '{32'h0, 32'h0, 32'h0};
    tx_r = 1'b0;
    link = 1'b1;
    err = 1'b0;
    void'($urandom(79201));
    repeat (4) @(negedge clock_in);
    sys_rst_in = 1'b0;
    wr(`HFP_CFG, 32'h00101010);
    // Status queues: nonpop_status_port keeps the head, writes ignored, pop removes
    for (int q = 0; q < 2; q++) begin
      for (int i = 0; i < 3; i++) begin
        w = $urandom;
        exp_q.push_back(w);
        push(q * 2, w);
      end
      chk1(frdy[q * 2], 1'b1, "ready");
      rd(`HFP_RXS_NONPOP_STATUS_PORT + 6'(q * 2), w);
      chk32(w, exp_q[0], "nonpop_status_port");
      wr(`HFP_RXS_POP + 6'(q * 2), 32'h0);
      wr(`HFP_RXS_NONPOP_STATUS_PORT + 6'(q * 2), 32'h0);
      rd(`HFP_RXS_NONPOP_STATUS_PORT + 6'(q * 2), w);
      chk32(w, exp_q[0], "peek2");
      while (exp_q.size() > 0) begin
        rd(`HFP_RXS_POP + 6'(q * 2), w);
        chk32(w, exp_q.pop_front(), "pop");
      end
      rd(`HFP_RXS_POP + 6'(q * 2), w);
      chk32(w, 32'h0, "empty");
    end
    // Receive data through the aliases
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      exp_q.push_back(w);
      push(1, w);
    end
    wr(6'h05, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      rd(alias_addr(`HFP_RXD_WIN, i), w);
      chk32(w, exp_q.pop_front(), "rxd");
    end
    rd(6'h09, w);
    chk32(w, 32'h0, "rxd empty");
    // Transmit data with a stalled drain, then released
    for (int i = 0; i < 4; i++) begin
      w = $urandom;
      exp_q.push_back(w);
      wr(alias_addr(`HFP_TXD_WIN, i), w);
    end
    rd(6'h1a, w);
    chk32(w, 32'h0, "txd read");
    rd(`HFP_CTRL, w);
    chk32(w, 32'h0, "ctrl read");
    @(negedge clock_in);
    chk1(tx_v, 1'b1, "tx stalled");
    tx_r = 1'b1;
    // The word on the pins now is the one the next rising edge takes
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) begin
      if (tx_v === 1'b1) chk32(tx_d, exp_q.pop_front(), "txd");
      @(negedge clock_in);
    end
    chk32(32'(exp_q.size()), 32'h0, "txd drained");
    chk1(tx_v, 1'b0, "tx idle");
    // Latched and clearing status bits
    rd(`HFP_STAT, w);
    chk1(w[`HFP_ST_LINK], 1'b0, "link rst");
    rd(`HFP_STAT, w);
    chk1(w[`HFP_ST_LINK], 1'b1, "link live");
    chk1(w[`HFP_ST_TXEMPTY], 1'b1, "tx empty");
    @(negedge clock_in) link = 1'b0;
    @(negedge clock_in) link = 1'b1;
    err = 1'b1;
    @(negedge clock_in) err = 1'b0;
    rd(`HFP_STAT, w);
    chk32(w & 32'hc, 32'h8, "latched");
    rd(`HFP_STAT, w);
    chk32(w & 32'hc, 32'h4, "reloaded");
    wr(`HFP_CFG, 32'h00101002);
    flood(1);
    flood(2);
    rd(`HFP_STAT, w);
    chk32(w & 32'h3, 32'h3, "ovf");
    rd(`HFP_STAT, w);
    chk32(w & 32'h3, 32'h1, "ovf read");
    wr(`HFP_STAT, 32'h0);
    rd(`HFP_STAT, w);
    chk1(w[`HFP_ST_RXOVF], 1'b1, "wc zero");
    wr(`HFP_STAT, 32'h1);
    rd(`HFP_STAT, w);
    chk1(w[`HFP_ST_RXOVF], 1'b0, "wc one");
    // Software reset keeps the configuration, empties the queues
    push(1, 32'h5a5a5a5a);
    wr(`HFP_CTRL, 32'h1);
    k = 0;
    for (int i = 0; i < 3; i++) begin
      if (srst === 1'b1) k++;
      @(negedge clock_in);
    end
    chk32(32'(k), 32'h1, "srst pulse");
    rd(`HFP_CFG, w);
    chk32(w, 32'h00101002, "cfg kept");
    rd(`HFP_STAT, w);
    chk32(w & 32'h3, 32'h0, "flags reset");
    rd(6'h00, w);
    chk32(w, 32'h0, "queue reset");
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'b0;
    rd(`HFP_CFG, w);
    chk32(w, `HFP_CFG_RST, "cfg sys rst");
    end_sim();
  end
endmodule
